//--- hdl/adcsc_pkg.sv
// Constants and types of the converter control and serial readout block.
// Assumes a 40 MHz system clock; the serial clock is sampled, not used.
package adcsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ        = 40_000_000;
  localparam int unsigned SCLK_TIMEOUT_MS   = 28;
  localparam int unsigned SCLK_TIMEOUT_CYC  =
    SCLK_TIMEOUT_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned CONV_TIME_US      = 1200;
  localparam int unsigned CONV_CYC          =
    CONV_TIME_US * (SYS_CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned TEMP_W    = 14;
  localparam int unsigned TEMP_PAD  = WORD_W - TEMP_W;
  localparam logic [15:0] CODE_MAX  = 16'h7fff;
  localparam logic [15:0] CODE_MIN  = 16'h8000;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RST      = 16'h8583;
  localparam int unsigned CFG_START_BIT = 15;
  localparam int unsigned CFG_MODE_BIT  = 8;
  localparam int unsigned CFG_TS_BIT    = 4;
  localparam int unsigned CFG_NOP_HI    = 2;
  localparam int unsigned CFG_NOP_LO    = 1;
  localparam logic [1:0]  CFG_NOP_VALID = 2'h1;

  typedef enum logic [1:0] {
    ADCSC_IDLE,
    ADCSC_CONV_CONT,
    ADCSC_CONV_SINGLE
  } adcsc_state_t;

endpackage

//--- hdl/adcsc_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the output is read only in the i_clk_sys domain.
`timescale 1ns/100ps
module adcsc_sync
  import adcsc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= RST_VAL;
      o_sync   <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule

//--- hdl/adcsc_buf2.sv
// Two-entry valid/ready buffer between the converter and the readout.
// Assumes both sides run on i_clk_sys.
`timescale 1ns/100ps
module adcsc_buf2
  import adcsc_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  initial begin
    if (DEPTH != 2 || WIDTH < 1) $error("adcsc_buf2: bad parameters");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       cnt_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_reg != 2'h2);
  assign o_out_valid = (cnt_reg != 2'h0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- hdl/adcsc_top.sv
// Conversion sequencing and serial readout of a 16-bit converter.
// Assumes a 40 MHz i_clk_sys; serial pins come from the host's domain.
// Summary of operation
// - Results are 16-bit two's complement, 7fff high and 8000 low.
// - Over-range inputs saturate at the extreme codes, never wrap.
// - Temperature result is 14 bits left-justified, two low bits zero.
// - One temperature step is 0.03125 degrees; negatives two's complement.
// - Result is read as two bytes, most significant byte first.
// - Continuous mode stores each result and restarts at once.
// - Single-shot waits for the start bit, then clears it while busy.
// - Single-shot completion powers down; sets the start bit unless a valid config write lands in that cycle.
// - Start written during a conversion is ignored, never queued.
// - Power-up reset loads every configuration bit with its default.
// - After start-up powered down, no conversion until config written.
// - Chip select high resets serial logic; output released, no ready.
// - Chip select fall shows ready: low if new result, else high.
// - Result locked into shift register at transfer start.
// - Serial clock low for the timeout resets the serial logic.
// - Three-wire use with chip select tied low also works.
// - Data input sampled on serial clock falling edge, never driven.
// - Each output bit shifted out on serial clock rising edge.
`timescale 1ns/100ps
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = SCLK_TIMEOUT_CYC,
  parameter int unsigned CONV_TIME   = CONV_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic        i_din,
  output logic             o_serial_out_with_ready,
  output logic             o_serial_out_with_ready_oe,
  input  wire logic signed [17:0] i_adc_raw,
  input  wire logic signed [13:0] i_temp_raw,
  output logic      [15:0] o_cfg,
  output logic             o_converting
);
  initial begin
    if (TIMEOUT_CYC < 2 || CONV_TIME < 2) begin
      $error("adcsc_top: counts too small");
    end
  end

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rstn_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rstn_reg     <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rstn_reg     <= rst_meta_reg;
    end
  end

  logic cs_n_s;
  logic sclk_s;
  logic din_s;

  adcsc_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (rstn_reg),
    .i_async   (i_cs_n),
    .o_sync    (cs_n_s)
  );
  adcsc_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (rstn_reg),
    .i_async   (i_sclk),
    .o_sync    (sclk_s)
  );
  adcsc_sync #(.RST_VAL(1'b0)) u_sync_din (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (rstn_reg),
    .i_async   (i_din),
    .o_sync    (din_s)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclk_d_reg;
  logic cs_n_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;

  always_ff @(posedge i_clk_sys or negedge rstn_reg) begin
    if (!rstn_reg) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_reg && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_reg && !cs_n_s;
  assign cs_fall   = !cs_n_s && cs_n_d_reg;

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  function automatic logic [15:0] clip16(input logic signed [17:0] v);
    if (v > $signed(18'(CODE_MAX)))
      clip16 = CODE_MAX;
    else if (v < $signed({{2{1'b1}}, CODE_MIN}))
      clip16 = CODE_MIN;
    else
      clip16 = v[15:0];
  endfunction

  logic [15:0] cfg_reg;
  logic [15:0] new_result;

  // 0.03125 degree steps in two's complement, two low zeros
  assign new_result = cfg_reg[CFG_TS_BIT] ?
    {i_temp_raw, {TEMP_PAD{1'b0}}} : clip16(i_adc_raw);

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  logic [15:0] sh_out_reg;
  logic [15:0] sh_in_reg;
  logic [4:0]  bit_cnt_reg;
  logic        active_reg;
  logic        cfg_wr;
  logic        to_fire;
  logic [$clog2(TIMEOUT_CYC+1)-1:0] to_cnt_reg;

  // Config taken when sixteenth bit arrives
  assign cfg_wr = sclk_fall && (bit_cnt_reg == 5'd15);

  // Word as it stands on the sixteenth fall; refused unless marked valid
  logic [15:0] cfg_in;
  logic        cfg_ok;

  assign cfg_in = {sh_in_reg[14:0], din_s};
  assign cfg_ok = cfg_wr &&
    (cfg_in[CFG_NOP_HI:CFG_NOP_LO] == CFG_NOP_VALID);

  always_ff @(posedge i_clk_sys or negedge rstn_reg) begin
    if (!rstn_reg) begin
      to_cnt_reg <= '0;
    end else if (cs_n_s || sclk_s) begin
      to_cnt_reg <= '0;
    end else if (!to_fire) begin
      to_cnt_reg <= to_cnt_reg + 1'b1;
    end
  end
  // Released as soon as the clock rises, so that edge opens a new frame
  assign to_fire = !cs_n_s && !sclk_s && (to_cnt_reg ==
    ($clog2(TIMEOUT_CYC+1))'(TIMEOUT_CYC - 1));

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  adcsc_state_t state_reg;
  logic [$clog2(CONV_TIME+1)-1:0] conv_cnt_reg;
  logic        conv_done;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic [15:0] buf_out_data;
  logic [15:0] result_reg;
  logic        new_data_reg;
  logic        take;

  assign conv_done = (state_reg != ADCSC_IDLE) &&
    (conv_cnt_reg == ($clog2(CONV_TIME+1))'(CONV_TIME - 1)) &&
    buf_in_ready;
  always_ff @(posedge i_clk_sys or negedge rstn_reg) begin
    if (!rstn_reg) begin
      state_reg    <= ADCSC_IDLE;
      conv_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ADCSC_IDLE: begin
          conv_cnt_reg <= '0;
          if (cfg_ok && !cfg_in[CFG_MODE_BIT]) begin
            state_reg <= ADCSC_CONV_CONT;
          end else if (cfg_ok && cfg_in[CFG_MODE_BIT] &&
                       cfg_in[CFG_START_BIT]) begin
            state_reg <= ADCSC_CONV_SINGLE;
          end
        end
        ADCSC_CONV_CONT: begin
          if (conv_done) begin
            conv_cnt_reg <= '0;
          end else if (conv_cnt_reg !=
              ($clog2(CONV_TIME+1))'(CONV_TIME - 1)) begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
          end
          if (cfg_ok && cfg_in[CFG_MODE_BIT]) begin
            state_reg <= ADCSC_IDLE;
          end
        end
        ADCSC_CONV_SINGLE: begin
          // Further start requests are ignored here
          if (conv_done) begin
            state_reg <= ADCSC_IDLE;
          end else if (conv_cnt_reg !=
              ($clog2(CONV_TIME+1))'(CONV_TIME - 1)) begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------------
  logic [15:0] cfg_next;

  always_comb begin
    cfg_next = cfg_in;
    cfg_next[CFG_START_BIT] = 1'b1;
    if (state_reg == ADCSC_CONV_SINGLE && !conv_done) begin
      cfg_next[CFG_START_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rstn_reg) begin
    if (!rstn_reg) begin
      cfg_reg <= CFG_RST;
    end else if (cfg_ok) begin
      cfg_reg <= cfg_next;
      if (state_reg == ADCSC_IDLE && cfg_next[CFG_MODE_BIT] &&
          cfg_in[CFG_START_BIT]) begin
        cfg_reg[CFG_START_BIT] <= 1'b0;
      end else if (state_reg == ADCSC_CONV_SINGLE) begin
        cfg_reg[CFG_START_BIT] <= 1'b0;
      end
    end else if (state_reg == ADCSC_CONV_SINGLE && conv_done) begin
      cfg_reg[CFG_START_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer and conversion register
  // ----------------------------------------------------------------
  adcsc_buf2 #(.WIDTH(WORD_W), .DEPTH(2)) u_buf (
    .i_clk_sys   (i_clk_sys),
    .i_rstn      (rstn_reg),
    .i_in_valid  (conv_done),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (new_result),
    .o_out_valid (buf_out_valid),
    .i_out_ready (!active_reg),
    .o_out_data  (buf_out_data)
  );

  // Register not updated mid-transfer, so locked word stays intact
  assign take = buf_out_valid && !active_reg;

  always_ff @(posedge i_clk_sys or negedge rstn_reg) begin
    if (!rstn_reg) begin
      result_reg   <= RESULT_RST;
      new_data_reg <= 1'b0;
    end else begin
      if (take) begin
        result_reg <= buf_out_data;
      end
      if (take) begin
        new_data_reg <= 1'b1;
      end else if (active_reg && bit_cnt_reg == 5'd16) begin
        new_data_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rstn_reg) begin
    if (!rstn_reg) begin
      active_reg  <= 1'b0;
      bit_cnt_reg <= 5'd0;
      sh_out_reg  <= RESULT_RST;
      sh_in_reg   <= 16'h0000;
    end else if (cs_n_s || to_fire) begin
      active_reg  <= 1'b0;
      bit_cnt_reg <= 5'd0;
    end else if (sclk_rise) begin
      if (!active_reg) begin
        active_reg <= 1'b1;
        sh_out_reg <= {result_reg[14:0], 1'b0};
      end else begin
        sh_out_reg <= {sh_out_reg[14:0], 1'b0};
      end
    end else if (sclk_fall && active_reg) begin
      sh_in_reg   <= {sh_in_reg[14:0], din_s};
      if (bit_cnt_reg != 5'd16) begin
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rstn_reg) begin
    if (!rstn_reg) begin
      o_serial_out_with_ready    <= 1'b1;
      o_serial_out_with_ready_oe <= 1'b0;
      o_cfg                      <= CFG_RST;
      o_converting               <= 1'b0;
    end else begin
      o_serial_out_with_ready_oe <= !cs_n_s;
      if (cs_n_s) begin
        o_serial_out_with_ready <= 1'b1;
      end else if (!active_reg && !sclk_rise) begin
        o_serial_out_with_ready <= !new_data_reg;
      end else if (sclk_rise) begin
        // MSB first; high byte then low byte
        o_serial_out_with_ready <= active_reg ? sh_out_reg[15] :
                                                result_reg[15];
      end
      o_cfg        <= cfg_reg;
      o_converting <= (state_reg != ADCSC_IDLE);
    end
  end
endmodule

//--- sim/adcsc_properties.sv
// Concurrent checks on the ports of the converter control block.
// Assumes it is bound into adcsc_top and sees one clock domain.
`timescale 1ns/100ps
module adcsc_properties
  import adcsc_pkg::*;
#(
  parameter int unsigned CONV_TIME = CONV_CYC
) (
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_cs_n,
  input wire logic        o_serial_out_with_ready_oe,
  input wire logic [15:0] o_cfg,
  input wire logic        o_converting
);
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  int unsigned conv_cnt;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      conv_cnt <= 0;
    end else if (o_converting && o_cfg[CFG_MODE_BIT]) begin
      conv_cnt <= conv_cnt + 1;
    end else begin
      conv_cnt <= 0;
    end
  end
  sequence s_single_end;
    $fell(o_converting) && o_cfg[CFG_MODE_BIT];
  endsequence
  sequence s_single_busy;
    (o_converting && o_cfg[CFG_MODE_BIT]) [*3];
  endsequence
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  a_oe_release: assert property (
    i_cs_n [*4] |-> !o_serial_out_with_ready_oe)
    else $error("Output driven while deselected");
  a_oe_select: assert property (
    !i_cs_n [*5] |-> o_serial_out_with_ready_oe)
    else $error("Output not driven while selected");
  a_start_clears: assert property (
    s_single_busy |-> !o_cfg[CFG_START_BIT])
    else $error("Start bit high during conversion");
  a_single_done: assert property (
    s_single_end |-> ##[0:2] o_cfg[CFG_START_BIT])
    else $error("Start bit not set at completion");
  a_no_queue: assert property (
    s_single_end |=> !o_converting [*8])
    else $error("Conversion restarted after single shot");
  a_cont_restart: assert property (
    o_converting && !o_cfg[CFG_MODE_BIT] |=>
      o_converting || o_cfg[CFG_MODE_BIT])
    else $error("Continuous mode did not restart");
  a_conv_bound: assert property (
    o_converting |-> conv_cnt <= CONV_TIME + 2)
    else $error("Single conversion ran too long");
  a_cfg_needs_cs: assert property (
    $changed(o_cfg[14:1]) |-> !$past(i_cs_n, 3))
    else $error("Configuration changed without selection");
endmodule

bind adcsc_top adcsc_properties #(.CONV_TIME(CONV_TIME)) u_props (
  .i_clk_sys                  (i_clk_sys),
  .i_rstn                     (i_rstn),
  .i_cs_n                     (i_cs_n),
  .o_serial_out_with_ready_oe (o_serial_out_with_ready_oe),
  .o_cfg                      (o_cfg),
  .o_converting               (o_converting)
);

//--- sim/adcsc_host.sv
// Serial host model: frames of up to 16 bits, MSB first, 200 ns clock.
// Assumes the bench resolves the released data pin into i_pin.
`timescale 1ns/100ps
module adcsc_host (
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din,
  input  wire logic i_pin
);
  logic slow;
  logic keep_cs;
  initial begin
    o_cs_n  = 1'b1;
    o_sclk  = 1'b0;
    o_din   = 1'b0;
    slow    = 1'b0;
    keep_cs = 1'b0;
  end
  // ------------------------------------------------
  // One frame: ready sampled, then nbits clocks
  // ------------------------------------------------
  task automatic xfer(input int nbits, input logic [15:0] w,
                      output logic rdy, output logic [15:0] rx);
    rx = 16'h0000;
    o_cs_n = 1'b0;
    #400;
    rdy = i_pin;
    for (int i = 0; i < nbits; i++) begin
      o_din = w[15-i];
      #10;
      o_sclk = 1'b1;
      #100;
      o_sclk = 1'b0;
      #90;
      rx = {rx[14:0], i_pin};
      if (slow) begin
        #3000;
      end
    end
    #60;
    if (!keep_cs) begin
      o_cs_n = 1'b1;
    end
    #400;
  endtask
endmodule

//--- sim/adcsc_top_tb.sv
// Self-checking bench of the converter control and serial readout.
// Assumes adcsc_host as serial master and a 40 MHz system clock.
`timescale 1ns/100ps
module adcsc_top_tb import adcsc_pkg::*;;
  localparam int unsigned CONV_SIM = 400;
  localparam int          LIMIT    = 30000;
  logic               i_clk_sys, i_rstn, cs_n, sclk, din, out, oe, conv;
  logic               last_q = 1'b0;
  logic        [17:0] adc_raw;
  logic        [13:0] temp_raw;
  logic        [15:0] cfg;
  wire  logic         pin;
  int                 err_count = 0, num_checks = 0, cyc = 0;
  assign pin = oe ? out : ~last_q;
  always @(posedge i_clk_sys) begin
    if (oe) begin
      last_q <= out;
    end
  end
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  adcsc_top #(.TIMEOUT_CYC(200), .CONV_TIME(CONV_SIM)) dut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_din(din), .o_serial_out_with_ready(out),
    .o_serial_out_with_ready_oe(oe), .i_adc_raw(adc_raw),
    .i_temp_raw(temp_raw), .o_cfg(cfg), .o_converting(conv));
  adcsc_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_pin(pin));
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      results();
    end
  end
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset();
    check("reset config", cfg, CFG_RST);
    check("reset idle", 16'(conv), 16'h0000);
    check("reset released", 16'(oe), 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_idle_read();
    logic        rdy;
    logic [15:0] rx;
    host.xfer(16, 16'h0581, rdy, rx);
    check("no new ready", 16'(rdy), 16'h0001);
    check("reset result", rx, RESULT_RST);
    check("bad config", cfg, CFG_RST);
    check("still idle", 16'(conv), 16'h0000);
    $display("test idle read done");
  endtask
  task automatic t_single(input logic [15:0] w, input logic [17:0] raw,
                          input logic [13:0] tmp, input logic [15:0] exp);
    logic        rdy;
    logic [15:0] rx;
    @(negedge i_clk_sys);
    adc_raw  = raw;
    temp_raw = tmp;
    host.xfer(16, w, rdy, rx);
    check("old ready", 16'(rdy), 16'h0001);
    check("start busy", 16'(cfg[CFG_START_BIT]), 16'h0000);
    host.xfer(16, w, rdy, rx);
    for (int n = 0; n < 600 && conv !== 1'b0; n++) begin
      @(negedge i_clk_sys);
    end
    check("start done", 16'(cfg[CFG_START_BIT]), 16'h0001);
    repeat (20) @(negedge i_clk_sys);
    check("no requeue", 16'(conv), 16'h0000);
    host.xfer(16, 16'h0583, rdy, rx);
    check("new ready", 16'(rdy), 16'h0000);
    check("result", rx, exp);
    $display("test single %h done", exp);
  endtask
  task automatic t_cont();
    logic        rdy;
    logic [15:0] rx;
    @(negedge i_clk_sys);
    adc_raw = 18'h01234;
    host.xfer(16, 16'h0483, rdy, rx);
    repeat (2 * CONV_SIM) @(negedge i_clk_sys);
    host.slow = 1'b1;
    fork
      host.xfer(16, 16'h0483, rdy, rx);
      begin
        repeat (40) @(negedge i_clk_sys);
        adc_raw = 18'h00abc;
      end
    join
    host.slow = 1'b0;
    check("locked word", rx, 16'h1234);
    host.xfer(16, 16'h0583, rdy, rx);
    check("next word", rx, 16'h0abc);
    repeat (CONV_SIM + 20) @(negedge i_clk_sys);
    $display("test continuous done");
  endtask
  task automatic t_abort();
    logic        rdy;
    logic [15:0] rx;
    host.xfer(5, 16'h0000, rdy, rx);
    host.xfer(16, 16'h0593, rdy, rx);
    check("after deselect", rx, 16'h0abc);
    check("config taken", cfg, 16'h8593);
    host.keep_cs = 1'b1;
    host.xfer(5, 16'h0000, rdy, rx);
    repeat (300) @(negedge i_clk_sys);
    host.keep_cs = 1'b0;
    host.xfer(16, 16'h0583, rdy, rx);
    check("after timeout", rx, 16'h0abc);
    check("config timeout", cfg, 16'h8583);
    $display("test abort done");
  endtask
  initial begin
    i_rstn   = 1'b0;
    adc_raw  = 18'h00000;
    temp_raw = 14'h0000;
    repeat (5) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    t_reset();
    t_idle_read();
    t_single(16'h8583, 18'h1ffff, 14'h0000, CODE_MAX);
    t_single(16'h8583, 18'h20000, 14'h0000, CODE_MIN);
    t_single(16'h8583, 18'h07fff, 14'h0000, 16'h7fff);
    t_single(16'h8583, 18'h3ffff, 14'h0000, 16'hffff);
    t_single(16'h8583, 18'h37fff, 14'h0000, 16'h8000);
    t_single(16'h8583, 18'h00001, 14'h0000, 16'h0001);
    t_single(16'h8593, 18'h00000, 14'h3ce0, {14'h3ce0, 2'h0});
    t_single(16'h8593, 18'h00000, 14'h0960, {14'h0960, 2'h0});
    t_cont();
    t_abort();
    results();
  end
endmodule
